// File: inc/mtc_cfg.svh
// Constants of the multimode timer counter: offsets, fields, resets, timing
`ifndef MTC_CFG_SVH
`define MTC_CFG_SVH

// Register byte offsets on the Wishbone bus
`define MTC_ADR_CTRL 8'h00
`define MTC_ADR_MATCH 8'h04
`define MTC_ADR_CAPTURE 8'h08
`define MTC_ADR_STATUS 8'h0C

// Control register fields
`define MTC_CTRL_W 11
`define MTC_F_MODE_LSB 0
`define MTC_F_MODE_MSB 2
`define MTC_F_START_LSB 3
`define MTC_F_START_MSB 4
`define MTC_F_CLKSEL_LSB 5
`define MTC_F_CLKSEL_MSB 6
`define MTC_F_ACAP 7
`define MTC_F_TSTOP 8
`define MTC_F_CAPMODE 9
`define MTC_F_WINNEG 10

// Status register fields above the live count
`define MTC_ST_RUN 16
`define MTC_ST_PEND 17
`define MTC_ST_LEVEL 18

// Mode codes of the control field
`define MTC_MODE_TIMER 3'h0
`define MTC_MODE_EXT 3'h1
`define MTC_MODE_EVENT 3'h2
`define MTC_MODE_WINDOW 3'h3
`define MTC_MODE_PULSE 3'h4

// Start field codes
`define MTC_START_STOP 2'h0
`define MTC_START_CMD 2'h1
`define MTC_START_RISE 2'h2
`define MTC_START_FALL 2'h3

// Reset values
`define MTC_CTRL_RST 11'h000
`define MTC_MATCH_RST 16'hFFFF
`define MTC_CAPTURE_RST 16'h0000

// Noise filter in fast-clock periods; the hold count sits between limits
`define MTC_FILT_REJECT_FC 4
`define MTC_FILT_DETECT_FC 12
`define MTC_FILT_HOLD ((`MTC_FILT_REJECT_FC + `MTC_FILT_DETECT_FC) / 2)
`define MTC_FILT_CW 4

// Source clock dividers as powers of two, per clock select code
`define MTC_DIV_LOG0 11
`define MTC_DIV_LOG1 7
`define MTC_DIV_LOG2 3
`define MTC_DIV_LOG3 0
`define MTC_DIV_W 11

`endif

// File: inc/mtc_pkg.sv
// Types shared by the multimode timer counter modules
package mtc_pkg;
`include "mtc_cfg.svh"

	// Decoded operating mode
	typedef enum logic [2:0] {
		MTC_M_TIMER,
		MTC_M_EXT,
		MTC_M_EVENT,
		MTC_M_WINDOW,
		MTC_M_PULSE,
		MTC_M_IDLE
	} mtc_mode_t;

	// State of the pin filter
	typedef struct packed {
		logic [2:0] sync;
		logic [`MTC_FILT_CW-1:0] cnt;
		logic level;
	} mtc_filt_t;

	// State of the source clock divider
	typedef struct packed {
		logic [`MTC_DIV_W-1:0] cnt;
	} mtc_div_t;

	// State of the timer core
	typedef struct packed {
		logic [`MTC_CTRL_W-1:0] ctrl;
		logic [15:0] cnt;
		logic [15:0] match;
		logic [7:0] match_lo;
		logic [15:0] pend_val;
		logic pend;
		logic [15:0] capture;
		logic run;
		logic pin_prev;
		logic ack;
		logic [31:0] rdata;
		logic irq;
	} mtc_state_t;

endpackage : mtc_pkg

// File: verilog/mtc_prescaler.sv
// Source clock divider giving one-cycle tick enables
module mtc_prescaler
	import mtc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [1:0] sel_i,
	output logic tick_o
);

	mtc_div_t st_reg;
	mtc_div_t st_next;
	logic [3:0] ticks; // One tick per select code

	// Tick when the low bits of the free counter are all ones
	generate
		for (genvar g = 0; g < 4; g++) begin : g_tick
			localparam int LG = (g == 0) ? `MTC_DIV_LOG0 :
				(g == 1) ? `MTC_DIV_LOG1 :
				(g == 2) ? `MTC_DIV_LOG2 : `MTC_DIV_LOG3;
			localparam int M1 = (1 << LG) - 1;
			localparam logic [`MTC_DIV_W-1:0] MASK = M1[`MTC_DIV_W-1:0];
			assign ticks[g] = (st_reg.cnt & MASK) == MASK;
		end
	endgenerate

	assign tick_o = ticks[sel_i];

	// Free-running count; never stopped so rates stay phase-stable
	always_comb begin
		st_next = st_reg;
		st_next.cnt = st_reg.cnt + 1'b1;
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule : mtc_prescaler

// File: verilog/mtc_pin_filter.sv
// Synchroniser and noise filter for the timer input pin
module mtc_pin_filter
	import mtc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	input wire logic bypass_i,
	output logic level_o
);

	mtc_filt_t st_reg;
	mtc_filt_t st_next;
	logic agree; // Second and third stage match

	assign agree = st_reg.sync[1] == st_reg.sync[2];
	assign level_o = st_reg.level;

	// Short pulses never reach the hold count, so they are dropped
	always_comb begin
		st_next = st_reg;
		st_next.sync = {st_reg.sync[1:0], pin_i};
		st_next.cnt = '0;
		if (bypass_i) begin
			// Low power: take the synchronised level directly
			if (agree) begin
				st_next.level = st_reg.sync[2];
			end
		end else if (agree && st_reg.sync[2] != st_reg.level) begin
			// Count the time the new level stays put
			if (st_reg.cnt == `MTC_FILT_CW'(`MTC_FILT_HOLD - 1)) begin
				st_next.level = st_reg.sync[2];
			end else begin
				st_next.cnt = st_reg.cnt + 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_FILT_HOLD: assert property (
		(!$past(bypass_i) && $changed(st_reg.level)) |->
		$past(st_reg.cnt) == `MTC_FILT_CW'(`MTC_FILT_HOLD - 1))
		else $error("filter level changed before hold count");
	AST_FILT_BYPASS: assert property (
		(bypass_i && agree) |=> st_reg.level == $past(st_reg.sync[2]))
		else $error("bypassed filter did not follow the pin");

endmodule : mtc_pin_filter

// File: verilog/mtc_timer.sv
// Multimode 16-bit timer counter with Wishbone register access
//
// Notes on behaviour
// - Timer mode: count ticks, match interrupts and clears
// - Auto-capture copies count each source clock in timer, event and window modes (pin edge in event mode)
// - External trigger: selected pin edge starts counting
// - External trigger: match clears, halts, interrupts
// - Stop select one: opposite edge clears, halts quietly
// - External trigger: halted counter restarts from zero on trigger
// - Stop select zero: opposite and early triggers ignored
// - Filter drops short pulses, passes long ones
// - Low power modes bypass the pin filter
// - Event mode: count pin edges, match clears
// - Event match acts on the opposite edge
// - Window mode: pin level gates tick counting
// - Single capture: opposite edge captures, sets count to one, halts
// - Double capture: both edges capture, trigger clears
// - Single capture holds count at one
// - Match value loads on next source clock after upper byte (pin edge in event mode)
// - Stop power mode forces start field to stop
module mtc_timer
	import mtc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic timer_input_pin_i,
	input wire logic low_power_i,
	input wire logic stop_mode_i,
	output logic timer_one_irq_o
);

	// Decode the three-bit mode field into the mode type
	function automatic mtc_mode_t mtc_decode_mode(input logic [2:0] code);
		mtc_mode_t m;
		m = MTC_M_IDLE;
		case (code)
			`MTC_MODE_TIMER: m = MTC_M_TIMER;
			`MTC_MODE_EXT: m = MTC_M_EXT;
			`MTC_MODE_EVENT: m = MTC_M_EVENT;
			`MTC_MODE_WINDOW: m = MTC_M_WINDOW;
			`MTC_MODE_PULSE: m = MTC_M_PULSE;
			default: m = MTC_M_IDLE;
		endcase
		return m;
	endfunction : mtc_decode_mode

	mtc_state_t st_reg; // All timer state
	mtc_state_t st_next; // Its next value
	mtc_mode_t mode; // Decoded mode
	logic [1:0] start; // Start field
	logic run_en; // Start field is not stop
	logic acap; // Auto-capture enable
	logic tstop; // Trigger-stop select
	logic capmode; // One for single-edge capture
	logic winneg; // Window counts on low level
	logic tick; // Internal source clock enable
	logic lvl; // Filtered pin level
	logic rise; // Filtered rising edge
	logic fall; // Filtered falling edge
	logic trig; // Selected edge
	logic opp; // Opposite edge
	logic src_evt; // Source clock of the counter
	logic gate; // Window open
	logic hit; // Count equals match
	logic bus_req; // Bus access taken this cycle, acknowledged the next
	logic [7:0] bus_adr; // Word-aligned byte address

	// Control fields out of the control vector
	assign mode = mtc_decode_mode(
		st_reg.ctrl[`MTC_F_MODE_MSB:`MTC_F_MODE_LSB]);
	assign start = st_reg.ctrl[`MTC_F_START_MSB:`MTC_F_START_LSB];
	assign run_en = start != `MTC_START_STOP;
	assign acap = st_reg.ctrl[`MTC_F_ACAP];
	assign tstop = st_reg.ctrl[`MTC_F_TSTOP];
	assign capmode = st_reg.ctrl[`MTC_F_CAPMODE];
	assign winneg = st_reg.ctrl[`MTC_F_WINNEG];

	// Divider for the selectable internal source clock
	mtc_prescaler u_prescaler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sel_i(st_reg.ctrl[`MTC_F_CLKSEL_MSB:`MTC_F_CLKSEL_LSB]),
		.tick_o(tick)
	);

	// Pin synchroniser and filter; bypassed in low power modes
	mtc_pin_filter u_pin_filter (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(timer_input_pin_i),
		.bypass_i(low_power_i),
		.level_o(lvl)
	);

	// Edge detection on the filtered level; start 01 counts as rising
	assign rise = lvl & ~st_reg.pin_prev;
	assign fall = ~lvl & st_reg.pin_prev;
	assign trig = (start == `MTC_START_FALL) ? fall : rise;
	assign opp = (start == `MTC_START_FALL) ? rise : fall;
	// Event mode is clocked by the pin, all others by the divider
	assign src_evt = (mode == MTC_M_EVENT) ? trig : tick;
	assign gate = lvl ^ winneg;
	assign hit = st_reg.cnt == st_reg.match;
	assign bus_req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
	assign bus_adr = {wb_adr_i[7:2], 2'b00};

	assign wb_dat_o = st_reg.rdata;
	assign wb_ack_o = st_reg.ack;
	assign timer_one_irq_o = st_reg.irq;

	// Next-state logic: counter, capture, match staging and bus
	always_comb begin
		st_next = st_reg;
		st_next.irq = 1'b0;
		st_next.ack = bus_req;
		st_next.pin_prev = lvl;

		// Counting per mode
		if (!run_en) begin
			// Stopped: counter held clear, trigger disarmed
			st_next.cnt = '0;
			st_next.run = 1'b0;
		end else begin
			case (mode)
				MTC_M_TIMER: begin
					// Free running on the source tick
					if (tick) begin
						if (hit) begin
							st_next.irq = 1'b1;
							st_next.cnt = '0;
						end else begin
							st_next.cnt = st_reg.cnt + 1'b1;
						end
					end
				end
				MTC_M_EXT: begin
					if (!st_reg.run) begin
						// Armed: trigger edge starts from zero
						if (trig) begin
							st_next.run = 1'b1;
							st_next.cnt = '0;
						end
					end else if (tick && hit) begin
						// Match wins over any edge
						st_next.irq = 1'b1;
						st_next.cnt = '0;
						st_next.run = 1'b0;
					end else if (tstop && opp) begin
						// Pulse ended early: no interrupt
						st_next.cnt = '0;
						st_next.run = 1'b0;
					end else if (tick) begin
						// Edges while running are ignored otherwise
						st_next.cnt = st_reg.cnt + 1'b1;
					end
				end
				MTC_M_EVENT: begin
					// Count on the selected edge
					if (trig) begin
						st_next.cnt = st_reg.cnt + 1'b1;
					end else if (opp && hit) begin
						// Compare only on the opposite edge
						st_next.irq = 1'b1;
						st_next.cnt = '0;
					end
				end
				MTC_M_WINDOW: begin
					// Ticks only count while the window is open
					if (tick && gate) begin
						if (hit) begin
							st_next.irq = 1'b1;
							st_next.cnt = '0;
						end else begin
							st_next.cnt = st_reg.cnt + 1'b1;
						end
					end
				end
				MTC_M_PULSE: begin
					if (!st_reg.run) begin
						// Wait for the trigger edge; held count stays
						if (trig) begin
							st_next.run = 1'b1;
						end
					end else if (capmode) begin
						if (opp) begin
							// Single edge: capture and park at one
							st_next.capture = st_reg.cnt;
							st_next.irq = 1'b1;
							st_next.cnt = 16'h0001;
							st_next.run = 1'b0;
						end else if (tick) begin
							st_next.cnt = st_reg.cnt + 1'b1;
						end
					end else if (trig) begin
						// Double edge: period end, capture and clear
						st_next.capture = st_reg.cnt;
						st_next.irq = 1'b1;
						st_next.cnt = '0;
					end else begin
						// Mid-period edge captures without clearing
						if (opp) begin
							st_next.capture = st_reg.cnt;
							st_next.irq = 1'b1;
						end
						if (tick) begin
							st_next.cnt = st_reg.cnt + 1'b1;
						end
					end
				end
				default: begin
					// Unused mode codes leave the counter alone
					st_next.cnt = st_reg.cnt;
				end
			endcase
		end

		// Auto-capture on every source clock of a started timer, event or window counter
		if (acap && run_en && src_evt && (mode == MTC_M_TIMER ||
			mode == MTC_M_EVENT || mode == MTC_M_WINDOW)) begin
			st_next.capture = st_reg.cnt;
		end

		// Staged match value goes live on the next source clock
		if (st_reg.pend && src_evt) begin
			st_next.match = st_reg.pend_val;
			st_next.pend = 1'b0;
		end

		// Register access; a write lands with the acknowledge
		if (bus_req) begin
			st_next.rdata = '0;
			case (bus_adr)
				`MTC_ADR_CTRL: begin
					st_next.rdata[`MTC_CTRL_W-1:0] = st_reg.ctrl;
					if (wb_we_i && wb_sel_i[0]) begin
						st_next.ctrl[7:0] = wb_dat_i[7:0];
					end
					if (wb_we_i && wb_sel_i[1]) begin
						st_next.ctrl[`MTC_CTRL_W-1:8] =
							wb_dat_i[`MTC_CTRL_W-1:8];
					end
				end
				`MTC_ADR_MATCH: begin
					st_next.rdata[15:0] = st_reg.match;
					// Low byte alone is only staged
					if (wb_we_i && wb_sel_i[0]) begin
						st_next.match_lo = wb_dat_i[7:0];
					end
					// Upper byte commits the pair
					if (wb_we_i && wb_sel_i[1]) begin
						st_next.pend_val = {wb_dat_i[15:8],
							wb_sel_i[0] ? wb_dat_i[7:0] : st_reg.match_lo};
						st_next.pend = 1'b1;
					end
				end
				`MTC_ADR_CAPTURE: begin
					st_next.rdata[15:0] = st_reg.capture;
				end
				`MTC_ADR_STATUS: begin
					st_next.rdata[15:0] = st_reg.cnt;
					st_next.rdata[`MTC_ST_RUN] = st_reg.run;
					st_next.rdata[`MTC_ST_PEND] = st_reg.pend;
					st_next.rdata[`MTC_ST_LEVEL] = lvl;
				end
				default: begin
					// Unmapped words read zero and ignore writes
					st_next.rdata = '0;
				end
			endcase
		end

		// Stop power mode overrides any start written this cycle
		if (stop_mode_i) begin
			st_next.ctrl[`MTC_F_START_MSB:`MTC_F_START_LSB] =
				`MTC_START_STOP;
		end
	end

	// State register; reset leaves the timer stopped and clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
			st_reg.ctrl <= `MTC_CTRL_RST;
			st_reg.match <= `MTC_MATCH_RST;
			st_reg.capture <= `MTC_CAPTURE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_TIMER_MATCH: assert property (
		(mode == MTC_M_TIMER && run_en && tick && hit) |=>
		(timer_one_irq_o && st_reg.cnt == 16'h0000))
		else $error("timer match did not clear and interrupt");
	AST_AUTOCAP: assert property (
		(mode == MTC_M_TIMER && run_en && acap && tick) |=>
		st_reg.capture == $past(st_reg.cnt))
		else $error("auto-capture missed a source tick");
	AST_EXT_START: assert property (
		(mode == MTC_M_EXT && run_en && !st_reg.run && trig) |=>
		(st_reg.run && st_reg.cnt == 16'h0000))
		else $error("trigger edge did not start from zero");
	AST_EXT_MATCH: assert property (
		(mode == MTC_M_EXT && run_en && st_reg.run && tick && hit) |=>
		(timer_one_irq_o && !st_reg.run && st_reg.cnt == 16'h0000))
		else $error("external match did not halt and interrupt");
	AST_EXT_OPP: assert property (
		(mode == MTC_M_EXT && run_en && st_reg.run && tstop && opp &&
		!(tick && hit)) |=>
		(!timer_one_irq_o && !st_reg.run && st_reg.cnt == 16'h0000))
		else $error("opposite edge did not halt quietly");
	AST_EXT_NOSTOP: assert property (
		(mode == MTC_M_EXT && run_en && st_reg.run && !tstop && opp && !hit)
		|=> (st_reg.run && st_reg.cnt == $past(st_reg.cnt) + 16'($past(tick))))
		else $error("edge disturbed counting with stop select zero");
	AST_EVENT_COUNT: assert property (
		(mode == MTC_M_EVENT && run_en && trig) |=>
		st_reg.cnt == $past(st_reg.cnt) + 16'h0001)
		else $error("event edge not counted");
	AST_EVENT_MATCH: assert property (
		(timer_one_irq_o && $past(mode == MTC_M_EVENT)) |->
		($past(opp) && st_reg.cnt == 16'h0000))
		else $error("event interrupt not on the opposite edge");
	AST_WINDOW_GATE: assert property (
		(mode == MTC_M_WINDOW && run_en && !gate) |=> $stable(st_reg.cnt))
		else $error("counter moved with the window closed");
	AST_PULSE_SINGLE: assert property (
		(mode == MTC_M_PULSE && run_en && capmode && st_reg.run && opp) |=>
		(timer_one_irq_o && !st_reg.run && st_reg.cnt == 16'h0001 &&
		st_reg.capture == $past(st_reg.cnt)))
		else $error("single-edge capture wrong");
	AST_PULSE_DOUBLE: assert property (
		(mode == MTC_M_PULSE && run_en && !capmode && st_reg.run && trig)
		|=> (timer_one_irq_o && st_reg.run && st_reg.cnt == 16'h0000))
		else $error("double-edge period capture wrong");
	AST_MATCH_LOW: assert property (
		(bus_req && wb_we_i && bus_adr == `MTC_ADR_MATCH &&
		!wb_sel_i[1] && !st_reg.pend) |=> !st_reg.pend)
		else $error("low byte write armed a match update");
	AST_STOP_MODE: assert property (
		stop_mode_i |=> (!run_en ##1 st_reg.cnt == 16'h0000))
		else $error("stop power mode did not stop the timer");

	COV_TIMER_MATCH: cover property (
		mode == MTC_M_TIMER && timer_one_irq_o);
	COV_EXT_OPP: cover property (
		mode == MTC_M_EXT && run_en && st_reg.run && tstop && opp);
	COV_EVENT_MATCH: cover property (
		mode == MTC_M_EVENT && timer_one_irq_o);
	COV_PULSE_DOUBLE: cover property (
		mode == MTC_M_PULSE && !capmode && timer_one_irq_o ##[1:1000]
		timer_one_irq_o);

endmodule : mtc_timer

// File: dv/mtc_pulse_src.sv
// Model of the external pulse source on the timer input pin
module mtc_pulse_src (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [15:0] hi_i,
	output logic pin_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] hi_left_reg = 16'h0000; // Cycles of high phase still to go
	logic pin_reg = 1'b0; // Pin level; idles low between pulses

	assign pin_o = pin_reg;

	// Pin idles low; a start request gives one high pulse of hi_i cycles.
	// High phases shorter than two cycles are widened, as any real source
	// must hold each level that long; the bench keeps gaps long too.
	always @(posedge clk_i) begin
		if (go_i) begin
			hi_left_reg <= (hi_i < 16'h0002) ? 16'h0002 : hi_i;
			pin_reg <= 1'b1;
		end else if (hi_left_reg > 16'h0001) begin
			hi_left_reg <= hi_left_reg - 16'h0001;
		end else if (hi_left_reg == 16'h0001) begin
			hi_left_reg <= 16'h0000;
			pin_reg <= 1'b0;
		end
	end
endmodule : mtc_pulse_src

// File: dv/tb_top.sv
// Self-checking bench for the multimode timer counter
`include "mtc_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] a_ctl = `MTC_ADR_CTRL; // Register offsets
	localparam logic [7:0] a_mat = `MTC_ADR_MATCH;
	localparam logic [7:0] a_cap = `MTC_ADR_CAPTURE;
	localparam logic [7:0] a_st = `MTC_ADR_STATUS;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, lp = 1'b0, sm = 1'b0;
	logic go = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000, rq;
	logic [15:0] hi = 16'h0000, m, w;
	logic [31:0] dato;
	logic ack, irq, pin;
	int fail_count = 0, checked = 0, irq_n = 0, cyc_n = 0;
	int last_t = 0, per1 = 0, per2 = 0, k0, dv;

	// 250 MHz clock
	always #2 clk_i = ~clk_i;

	mtc_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack),
		.timer_input_pin_i(pin), .low_power_i(lp), .stop_mode_i(sm),
		.timer_one_irq_o(irq));

	mtc_pulse_src src_u (.clk_i(clk_i), .go_i(go), .hi_i(hi), .pin_o(pin));

	// Count interrupt pulses and the spacing of the last two
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (rst_i) begin
			irq_n <= 0;
		end else if (irq === 1'b1) begin
			irq_n <= irq_n + 1;
			per2 <= per1;
			per1 <= cyc_n - last_t;
			last_t <= cyc_n;
		end
	end

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle

	// One classic cycle; request held until ack is sampled high
	task wb(input logic w_i, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w_i;
		adr <= a;
		sel <= s;
		dat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 40);
		if (ack !== 1'b1) fail_count++;
		rq = dato;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task wr(input logic [7:0] a, input logic [15:0] d);
		wb(1'b1, a, 4'h3, {16'h0000, d});
	endtask : wr

	task rd(input logic [7:0] a);
		wb(1'b0, a, 4'hF, 32'h0000_0000);
	endtask : rd

	// Ask the source for one high pulse
	task pulse(input logic [15:0] n);
		@(posedge clk_i);
		hi <= n;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
	endtask : pulse

	task results;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	// Hang guard, far beyond the few thousand cycles the tests need
	initial begin
		#200000;
		fail_count++;
		results();
	end

	// Main sequence
	initial begin
		void'($urandom(70));
		m = 16'(8 + $urandom % 32);
		w = 16'(20 + $urandom % 16);
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(a_ctl); chk("ctrl_rst", rq, 32'h0000_0000);
		rd(a_mat); chk("match_rst", rq, 32'h0000_FFFF);
		wr(a_cap, 16'hAAAA);
		rd(a_cap); chk("cap_ro", rq, 32'h0000_0000);
		rd(a_st); chk("status_rst", rq, 32'h0000_0000);
		rd(8'h10); chk("unmapped", rq, 32'h0000_0000);
		$display("test reset done");
		// Low byte alone is only staged; upper byte commits the pair
		wr(a_ctl, 16'h0060);
		wb(1'b1, a_mat, 4'h1, {24'h00_0000, m[7:0]});
		idle(4);
		rd(a_mat); chk("match_lo", rq, 32'h0000_FFFF);
		wb(1'b1, a_mat, 4'h2, 32'h0000_0000);
		idle(4);
		rd(a_mat); chk("match_hi", rq, {16'h0000, m});
		// Timer mode with auto-capture; wait well past one tick first
		wr(a_ctl, 16'h00E8);
		idle(4 * m + 8);
		chk("period_eq", per1, per2);
		chk("period", per1, int'(m) + 1);
		rd(a_cap); chk("cap_range", {31'h0, rq[15:0] <= m}, 1);
		$display("test timer done");
		// External trigger, stop on opposite edge, then run on with stop select zero
		wr(a_ctl, 16'h0060); wr(a_mat, 16'h0014); idle(4);
		wr(a_ctl, 16'h0171);
		k0 = irq_n;
		pulse(10); idle(40);
		rd(a_st); chk("ext_halt", rq[15:0], 0);
		chk("ext_quiet", irq_n, k0);
		for (int i = 1; i <= 2; i++) begin
			pulse(60); idle(80);
			chk("ext_irq", irq_n, k0 + i);
		end
		rd(a_st); chk("ext_clear", rq[15:0], 0);
		wr(a_ctl, 16'h0060); wr(a_ctl, 16'h0071);
		pulse(10); idle(60);
		chk("ext_run_on", irq_n, k0 + 3);
		$display("test trigger done");
		// Event counter, noise filter and its bypass
		wr(a_ctl, 16'h0060); wr(a_ctl, 16'h0072); wr(a_mat, 16'h0005);
		pulse(16); idle(40); pulse(16); idle(40);
		rd(a_st); chk("evt_two", rq[15:0], 2);
		pulse(3); idle(40);
		rd(a_st); chk("evt_short", rq[15:0], 2);
		lp <= 1'b1;
		pulse(6); idle(30);
		lp <= 1'b0;
		rd(a_st); chk("evt_bypass", rq[15:0], 3);
		pulse(16); idle(40);
		k0 = irq_n;
		pulse(60); idle(30);
		rd(a_st); chk("evt_at_match", rq[15:0], 5);
		chk("evt_no_irq_yet", irq_n, k0);
		idle(60);
		chk("evt_irq", irq_n, k0 + 1);
		rd(a_st); chk("evt_clear", rq[15:0], 0);
		$display("test event done");
		// Window: count only while the pin is high
		wr(a_ctl, 16'h0060); wr(a_mat, 16'h03E8); idle(4);
		wr(a_ctl, 16'h006B); idle(20);
		pulse(w); idle(w + 40);
		rd(a_st);
		chk("win_count", rq[15:0], w);
		k0 = int'(rq[15:0]);
		idle(30);
		rd(a_st); chk("win_hold", rq[15:0], k0);
		$display("test window done");
		// Pulse width: single then double capture; first capture unused
		for (int i = 0; i < 2; i++) begin
			wr(a_ctl, 16'h0060);
			wr(a_ctl, (i == 0) ? 16'h0274 : 16'h0074);
			k0 = irq_n;
			repeat (2) begin
				pulse(w); idle(w + 60);
			end
			rd(a_cap);
			dv = int'(rq[15:0]) - int'(w);
			chk("pw_cap", {31'h0, dv >= -2 && dv <= 4}, 1);
			chk("pw_irq", irq_n, k0 + 2 + i);
			if (i == 0) begin
				rd(a_st); chk("pw_park", rq[15:0], 1);
			end
		end
		$display("test pulse done");
		// Stop power mode clears the start field
		sm <= 1'b1;
		idle(2);
		sm <= 1'b0;
		rd(a_ctl); chk("stop_start", {30'h0, rq[4:3]}, 0);
		$display("test stop done");
		// Reset in mid-run must leave the timer stopped and clear
		wr(a_ctl, 16'h00E8);
		idle(10);
		rst_i <= 1'b1;
		idle(2);
		rst_i <= 1'b0;
		rd(a_ctl); chk("ctrl_rerst", rq, 32'h0000_0000);
		rd(a_st); chk("status_rerst", rq, 32'h0000_0000);
		$display("test reset again done");
		results();
	end
endmodule : tb_top
